/* design/fcs_device.sv */
// flash command sequencer: page latch, keyed commands, lock and nvm bits
// assumes a master on fcs_if holding req until ack, and an array that
// accepts one word write per cycle on the user side
//
// What this block does
// [RL1] latch writes decode only low 8 address bits
// [RL2] master fills latch with whole words only
// [RL3] writes take one extra wait, none at 3
// [RL4] command codes decoded per fixed code table
// [RL5] command write clears done; finish sets, interrupts
// [RL6] commands need key 0x5A in top byte
// [RL7] bad key or code: reject flag, no change
// [RL8] status read clears reject and lock fault
// [RL9] locked page write or erase: lock fault only
// [RL10] skip bit clear erases page before programming
// [RL11] partial programming stays on word boundaries
// [RL12] program-then-lock locks region after programming
// [RL13] latch holds one page; command starts programming
// [RL14] erase-all refused if any region locked
// [RL15] region chosen by page index at bit 8
// [RL16] lock reads 1, unlock 0, cells inverted
// [RL17] reads served during lock and nvm commands
// [RL18] general bit index out of range ignored
// [RL19] general bit set reads 1, clear 0
// [RL20] security blocks debug; cleared by hardware erase
// [RL21] security status bit held while active
// [RL22] software sets microsecond count before commands
// [RL23] count per 1 us or 1.5 us
// [RL24] next command only after done flag
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module fcs_device (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// link to the bus master
	fcs_if.dev bus,
	// array side
	output logic arr_erase_o,
	output logic arr_wipe_o,
	output logic arr_wr_o,
	output logic [15:0] arr_addr_o,
	output logic [31:0] arr_wdata_o,
	output logic [19:0] arr_rd_addr_o,
	input wire logic [31:0] arr_rd_data_i,
	// nonvolatile state and erase pin
	input wire logic ext_erase_i,
	output logic security_o,
	output logic [2:0] gp_nvm_o
);
	typedef enum logic [2:0] {
		S_IDLE, S_ERASE, S_PROG, S_PWAIT, S_NVM, S_WIPE, S_HWIPE
	} fcs_state_t;

	// region count, declared ahead of the lock cells that it sizes
	localparam int REGIONS_L = fcs_pkg::REGIONS;

	// access wait cycles, ack comes this many edges after acceptance
	function automatic logic [2:0] fcs_wait(input logic [1:0] read_wait_states,
		input logic is_wr);
		if (!is_wr)
			return {1'b0, read_wait_states} + 3'h1;
		else if (read_wait_states == fcs_pkg::FWS_MAX) // [RL3]
			return {1'b0, read_wait_states} + 3'h1;
		else
			return {1'b0, read_wait_states} + 3'h2; // [RL3]
	endfunction : fcs_wait

	fcs_state_t state;
	logic [31:0] latch [0:63];
	logic [31:0] cfg;
	logic acc, k_reg, k_wr;
	logic [1:0] k_size;
	logic [20:0] k_addr;
	logic [31:0] k_wdata;
	logic [2:0] wcnt;
	logic fin, cmd_wr, st_rd;
	logic done, rej, lockf;
	logic ev_done, ev_rej, ev_lockf;
	logic [REGIONS_L-1:0] cell_n;
	logic [3:0] op;
	logic [9:0] page;
	logic [5:0] widx;
	logic [7:0] pre, us_left;
	logic e1, e2, e3, e_lvl, hw_evt;
	logic arr_busy;
	logic [31:0] stat;
	logic [3:0] c_code;
	logic c_key, c_valid, c_locked;
	logic [3:0] c_region;

	// the array is busy only for page and full erase and programming
	assign arr_busy = (state == S_ERASE) || (state == S_PROG) ||
		(state == S_PWAIT) || (state == S_WIPE) || (state == S_HWIPE);
	assign fin = acc && (wcnt == 3'h0);
	assign cmd_wr = fin && k_reg && k_wr && (k_addr[7:0] == fcs_pkg::CMD_OFF);
	assign st_rd = fin && k_reg && !k_wr &&
		(k_addr[7:0] == fcs_pkg::STAT_OFF);

	// command word decode
	assign c_code = k_wdata[3:0];
	assign c_key = k_wdata[31:fcs_pkg::CMD_KEY_LSB] == fcs_pkg::CMD_KEY; // [RL6]
	assign c_region = k_wdata[17:14]; // [RL15]
	assign c_locked = !cell_n[c_region];
	always_comb begin
		unique case (c_code) // [RL4]
			fcs_pkg::C_PROG, fcs_pkg::C_LOCK, fcs_pkg::C_PROG_LOCK,
			fcs_pkg::C_UNLOCK, fcs_pkg::C_WIPE, fcs_pkg::C_GP_SET,
			fcs_pkg::C_GP_CLR, fcs_pkg::C_SEC: c_valid = c_key;
			default: c_valid = 1'b0;
		endcase
	end

	// status image; lock cells are stored inverted
	always_comb begin
		stat = 32'h0000_0000;
		stat[fcs_pkg::ST_DONE] = done;
		stat[fcs_pkg::ST_LOCKF] = lockf;
		stat[fcs_pkg::ST_REJ] = rej;
		stat[fcs_pkg::ST_SEC] = security_o; // [RL21]
		stat[fcs_pkg::ST_GP_LSB +: 3] = gp_nvm_o;
		stat[fcs_pkg::ST_LOCK_LSB +: REGIONS_L] = ~cell_n; // [RL16]
	end

	// link slave: accept, count wait states, answer with a one-cycle ack
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			acc <= 1'b0;
			wcnt <= 3'h0;
			k_reg <= 1'b0;
			k_wr <= 1'b0;
			k_size <= 2'h0;
			k_addr <= 21'h00_0000;
			k_wdata <= 32'h0000_0000;
			bus.ack <= 1'b0;
			bus.rdata <= 32'h0000_0000;
			arr_rd_addr_o <= 20'h0_0000;
		end else begin
			bus.ack <= fin;
			if (acc) begin
				if (wcnt != 3'h0)
					wcnt <= wcnt - 3'h1;
				else
					acc <= 1'b0;
			// array reads stall while the array erases or programs; register reads do not
			end else if (bus.req && !bus.ack && !(arr_busy && !bus.wr &&
				!bus.addr[fcs_pkg::REG_SPACE_BIT])) begin // [RL17]
				acc <= 1'b1;
				k_reg <= bus.addr[fcs_pkg::REG_SPACE_BIT];
				k_wr <= bus.wr;
				k_size <= bus.size;
				k_addr <= bus.addr;
				k_wdata <= bus.wdata;
				arr_rd_addr_o <= bus.addr[19:0];
				if (bus.addr[fcs_pkg::REG_SPACE_BIT])
					wcnt <= 3'h0;
				else
					wcnt <= fcs_wait(cfg[fcs_pkg::CFG_FWS_LSB +: 2], bus.wr) -
						3'h1;
			end
			if (fin && !k_wr) begin
				if (!k_reg)
					bus.rdata <= arr_rd_data_i;
				else if (k_addr[7:0] == fcs_pkg::CFG_OFF)
					bus.rdata <= cfg;
				else if (k_addr[7:0] == fcs_pkg::STAT_OFF)
					bus.rdata <= stat;
				else
					bus.rdata <= 32'h0000_0000;
			end
		end
	end

	// page latch; byte and halfword writes are dropped, not merged
	always_ff @(posedge clk_sys_i) begin
		if (fin && !k_reg && k_wr && k_size == fcs_pkg::SZ_WORD) // [RL2]
			latch[k_addr[7:2]] <= k_wdata; // [RL1] [RL13]
	end

	// configuration register
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			cfg <= fcs_pkg::CFG_RESET;
		else if (fin && k_reg && k_wr && k_addr[7:0] == fcs_pkg::CFG_OFF)
			cfg <= k_wdata & 32'h00FF_038D;
	end

	// erase pin: three stages, a change counts once stages two and three agree
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			e1 <= 1'b0;
			e2 <= 1'b0;
			e3 <= 1'b0;
			e_lvl <= 1'b0;
		end else begin
			e1 <= ext_erase_i;
			e2 <= e1;
			e3 <= e2;
			if (e2 == e3)
				e_lvl <= e3;
		end
	end
	assign hw_evt = (e2 == e3) && e3 && !e_lvl;

	// sequencer, its microsecond timer and the nonvolatile bits
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= S_IDLE;
			op <= 4'h0;
			page <= 10'h000;
			widx <= 6'h00;
			pre <= 8'h00;
			us_left <= 8'h00;
			cell_n <= '1;
			gp_nvm_o <= 3'h0;
			security_o <= 1'b0;
			ev_done <= 1'b0;
			ev_rej <= 1'b0;
			ev_lockf <= 1'b0;
			arr_erase_o <= 1'b0;
			arr_wipe_o <= 1'b0;
			arr_wr_o <= 1'b0;
			arr_addr_o <= 16'h0000;
			arr_wdata_o <= 32'h0000_0000;
		end else begin
			ev_done <= 1'b0;
			ev_rej <= 1'b0;
			ev_lockf <= 1'b0;
			arr_erase_o <= 1'b0;
			arr_wipe_o <= 1'b0;
			arr_wr_o <= 1'b0;
			// timer ticks each us_cycle_count+1 cycles
			if (us_left != 8'h00) begin
				if (pre >= cfg[fcs_pkg::CFG_US_CYCLE_COUNT_LSB +: 8]) begin // [RL22] [RL23]
					pre <= 8'h00;
					us_left <= us_left - 8'h01;
				end else
					pre <= pre + 8'h01;
			end
			if (hw_evt) begin
				// hardware erase overrides whatever is running
				state <= S_HWIPE;
				arr_wipe_o <= 1'b1;
				pre <= 8'h00;
				us_left <= fcs_pkg::WIPE_US;
			end else begin
				unique case (state)
					S_IDLE: if (cmd_wr) begin // [RL24]
						op <= c_code;
						page <= k_wdata[17:8]; // [RL15]
						pre <= 8'h00;
						if (!c_valid) begin
							ev_rej <= 1'b1; // [RL7]
							ev_done <= 1'b1;
						end else if ((c_code == fcs_pkg::C_PROG ||
							c_code == fcs_pkg::C_PROG_LOCK) && c_locked) begin
							ev_lockf <= 1'b1; // [RL9]
							ev_done <= 1'b1;
						end else if (c_code == fcs_pkg::C_WIPE && !(&cell_n)) begin
							ev_lockf <= 1'b1; // [RL14]
							ev_done <= 1'b1;
						end else if (c_code == fcs_pkg::C_WIPE) begin
							state <= S_WIPE;
							arr_wipe_o <= 1'b1;
							us_left <= fcs_pkg::WIPE_US;
						end else if (c_code == fcs_pkg::C_PROG ||
							c_code == fcs_pkg::C_PROG_LOCK) begin
							widx <= 6'h00;
							if (cfg[fcs_pkg::CFG_SKIP])
								state <= S_PROG; // [RL10] [RL11]
							else begin
								state <= S_ERASE; // [RL10]
								arr_erase_o <= 1'b1;
								arr_addr_o <= {k_wdata[17:8], 6'h00};
								us_left <= fcs_pkg::ERASE_US;
							end
						end else begin
							state <= S_NVM;
							us_left <= fcs_pkg::NVM_US;
						end
					end
					S_ERASE: if (us_left == 8'h00)
						state <= S_PROG;
					S_PROG: begin
						// stream the latch into the array, one word a cycle
						arr_wr_o <= 1'b1; // [RL13]
						arr_addr_o <= {page, widx};
						arr_wdata_o <= latch[widx];
						widx <= widx + 6'h01;
						if (widx == 6'h3F) begin
							state <= S_PWAIT;
							pre <= 8'h00;
							us_left <= fcs_pkg::PROG_US;
						end
					end
					S_PWAIT: if (us_left == 8'h00) begin
						if (op == fcs_pkg::C_PROG_LOCK) begin
							state <= S_NVM; // [RL12]
							pre <= 8'h00;
							us_left <= fcs_pkg::NVM_US;
						end else begin
							state <= S_IDLE;
							ev_done <= 1'b1; // [RL5]
						end
					end
					S_NVM: if (us_left == 8'h00) begin
						state <= S_IDLE;
						ev_done <= 1'b1; // [RL5]
						if (op == fcs_pkg::C_LOCK || op == fcs_pkg::C_PROG_LOCK)
							cell_n[page[9:6]] <= 1'b0; // [RL16] [RL12]
						else if (op == fcs_pkg::C_UNLOCK)
							cell_n[page[9:6]] <= 1'b1; // [RL16]
						else if (op == fcs_pkg::C_SEC)
							security_o <= 1'b1; // [RL20]
						else if (page < 10'(fcs_pkg::GP_BITS)) // [RL18]
							gp_nvm_o[page[1:0]] <= (op == fcs_pkg::C_GP_SET); // [RL19]
					end
					S_WIPE: if (us_left == 8'h00) begin
						state <= S_IDLE;
						ev_done <= 1'b1;
					end
					S_HWIPE: if (us_left == 8'h00) begin
						// bits clear after the wipe, security in the same cycle as the rest
						state <= S_IDLE;
						cell_n <= '1;
						gp_nvm_o <= 3'h0;
						security_o <= 1'b0; // [RL20]
						ev_done <= 1'b1;
					end
				endcase
			end
		end
	end

	// flags: hardware set wins over the clear in the same cycle
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			done <= 1'b1;
			rej <= 1'b0;
			lockf <= 1'b0;
		end else begin
			if (ev_done)
				done <= 1'b1;
			else if (cmd_wr)
				done <= 1'b0; // [RL5]
			if (ev_rej)
				rej <= 1'b1;
			else if (st_rd)
				rej <= 1'b0; // [RL8]
			if (ev_lockf)
				lockf <= 1'b1;
			else if (st_rd)
				lockf <= 1'b0; // [RL8]
		end
	end

	// controller interrupt line, a registered level
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			bus.irq <= 1'b0;
		else
			bus.irq <= (done && cfg[fcs_pkg::CFG_DONE_IE]) || // [RL5]
				(lockf && cfg[fcs_pkg::CFG_LOCK_IE]) || // [RL14]
				(rej && cfg[fcs_pkg::CFG_REJ_IE]);
	end
endmodule : fcs_device

/* design/fcs_pkg.sv */
// constants shared by both ends of the flash command sequencer link
// assumes one 10 MHz system clock and a 21-bit link address space
package fcs_pkg;
	// link address map: bit 20 set selects the register space
	localparam int REG_SPACE_BIT = 20;
	localparam logic [7:0] CFG_OFF = 8'h60;
	localparam logic [7:0] CMD_OFF = 8'h64;
	localparam logic [7:0] STAT_OFF = 8'h68;
	// flash_config_reg fields
	localparam int CFG_DONE_IE = 0;
	localparam int CFG_LOCK_IE = 2;
	localparam int CFG_REJ_IE = 3;
	localparam int CFG_SKIP = 7;
	localparam int CFG_FWS_LSB = 8;
	localparam int CFG_US_CYCLE_COUNT_LSB = 16;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	// command_reg fields
	localparam int CMD_KEY_LSB = 24;
	localparam int CMD_IDX_LSB = 8;
	localparam logic [7:0] CMD_KEY = 8'h5A;
	// flash_state_reg fields
	localparam int ST_DONE = 0;
	localparam int ST_LOCKF = 2;
	localparam int ST_REJ = 3;
	localparam int ST_SEC = 4;
	localparam int ST_GP_LSB = 8;
	localparam int ST_LOCK_LSB = 16;
	// command codes
	localparam logic [3:0] C_PROG = 4'h1;
	localparam logic [3:0] C_LOCK = 4'h2;
	localparam logic [3:0] C_PROG_LOCK = 4'h3;
	localparam logic [3:0] C_UNLOCK = 4'h4;
	localparam logic [3:0] C_WIPE = 4'h8;
	localparam logic [3:0] C_GP_SET = 4'hB;
	localparam logic [3:0] C_GP_CLR = 4'hD;
	localparam logic [3:0] C_SEC = 4'hF;
	// array geometry
	localparam int PAGE_W = 10;
	localparam int WORD_W = 6;
	localparam int REGIONS = 16;
	localparam int REGION_W = 4;
	localparam int GP_BITS = 3;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] FWS_MAX = 2'h3;
	// array operation times in microseconds
	localparam logic [7:0] ERASE_US = 8'h0A;
	localparam logic [7:0] PROG_US = 8'h14;
	localparam logic [7:0] NVM_US = 8'h05;
	localparam logic [7:0] WIPE_US = 8'h32;
	// host register map (AHB-Lite side)
	localparam logic [7:0] H_ADDR = 8'h00;
	localparam logic [7:0] H_WDATA = 8'h04;
	localparam logic [7:0] H_GO = 8'h08;
	localparam logic [7:0] H_STAT = 8'h0C;
	localparam logic [7:0] H_RDATA = 8'h10;
endpackage : fcs_pkg

/* design/fcs_if.sv */
// link between the bus master end and the flash sequencer end
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface fcs_if;
	logic req;
	logic wr;
	logic [1:0] size;
	logic [20:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic ack;
	logic irq;
	modport dev(input req, wr, size, addr, wdata, output rdata, ack, irq);
	modport host(output req, wr, size, addr, wdata, input rdata, ack, irq);
endinterface : fcs_if

/* design/fcs_host.sv */
// bus master end: AHB-Lite slave registers that drive one link transfer
// assumes a single AHB-Lite master with word transfers and fcs_device
// on the far side of fcs_if
`timescale 1ns/1ps
module fcs_host (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// link to the sequencer
	fcs_if.host bus
);
	logic ap_valid, ap_wr;
	logic [7:0] ap_off;
	logic [31:0] wdata_reg, rdata_reg;
	logic [20:0] addr_reg;

	// never stalls, never errors
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	// address phase capture; read data is ready for the data phase
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ap_valid <= 1'b0;
			ap_wr <= 1'b0;
			ap_off <= 8'h00;
			hrdata_o <= 32'h0000_0000;
		end else if (hready_i) begin
			ap_valid <= hsel_i && htrans_i[1];
			ap_wr <= hwrite_i;
			ap_off <= haddr_i[7:0];
			unique case (haddr_i[7:0])
				fcs_pkg::H_ADDR: hrdata_o <= {11'h000, addr_reg};
				fcs_pkg::H_WDATA: hrdata_o <= wdata_reg;
				fcs_pkg::H_STAT: hrdata_o <= {30'h0000_0000, bus.irq, bus.req};
				fcs_pkg::H_RDATA: hrdata_o <= rdata_reg;
				default: hrdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// data phase writes into the staging registers
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			addr_reg <= 21'h00_0000;
			wdata_reg <= 32'h0000_0000;
		end else if (ap_valid && ap_wr) begin
			if (ap_off == fcs_pkg::H_ADDR)
				addr_reg <= hwdata_i[20:0];
			if (ap_off == fcs_pkg::H_WDATA)
				wdata_reg <= hwdata_i;
		end
	end

	// one link transfer per go write; a go while busy is dropped
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus.req <= 1'b0;
			bus.wr <= 1'b0;
			bus.size <= fcs_pkg::SZ_WORD;
			bus.addr <= 21'h00_0000;
			bus.wdata <= 32'h0000_0000;
			rdata_reg <= 32'h0000_0000;
		end else if (bus.req) begin
			if (bus.ack) begin
				bus.req <= 1'b0;
				rdata_reg <= bus.rdata;
			end
		end else if (ap_valid && ap_wr && ap_off == fcs_pkg::H_GO) begin
			bus.req <= 1'b1;
			bus.wr <= hwdata_i[0];
			bus.size <= hwdata_i[2:1]; // word size keeps the latch intact
			bus.addr <= addr_reg;
			bus.wdata <= wdata_reg;
		end
	end
endmodule : fcs_host

/* bench/fcs_asserts.sv */
// link checker for the sequencer: answer timing, handshake, interrupt line
// assumes it watches the one fcs_if that joins host and device ends
`timescale 1ns/1ps
module fcs_asserts (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// link signals
	input wire logic req,
	input wire logic wr,
	input wire logic [1:0] size,
	input wire logic [20:0] addr,
	input wire logic [31:0] wdata,
	input wire logic ack,
	input wire logic irq
);
	int cnt;
	logic [1:0] read_wait_states;
	logic [2:0] ie;
	logic regsp;
	logic cmd_wr;
	assign regsp = addr[fcs_pkg::REG_SPACE_BIT];
	assign cmd_wr = ack && req && wr && regsp && addr[7:0] == fcs_pkg::CMD_OFF;
	// edges with req up and no answer; the cycle before the take edge
	// counts too, so at the answer cnt is one more than the wait count
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			cnt <= 0;
		else if (req && !ack)
			cnt <= cnt + 1;
		else
			cnt <= 0;
	end
	// shadow of wait states and enables, updated at the config answer
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			read_wait_states <= 2'h0;
			ie <= 3'h0;
		end else if (ack && req && wr && regsp
			&& addr[7:0] == fcs_pkg::CFG_OFF) begin
			read_wait_states <= wdata[fcs_pkg::CFG_FWS_LSB +: 2];
			ie <= {wdata[fcs_pkg::CFG_REJ_IE], wdata[fcs_pkg::CFG_LOCK_IE],
				wdata[fcs_pkg::CFG_DONE_IE]};
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_wr_ans;
		ack && req && wr && !regsp;
	endsequence
	sequence s_rd_ans;
		ack && req && !wr && !regsp;
	endsequence
	sequence s_cmd_done_ie;
		cmd_wr && ie == 3'h1;
	endsequence
	sequence s_bad_key;
		cmd_wr && wdata[31:24] != fcs_pkg::CMD_KEY && ie[2];
	endsequence
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("answer longer than one cycle");
	ack_req_a: assert property (ack |-> req)
		else $error("answer without a request");
	req_drop_a: assert property (ack |=> !req)
		else $error("request not released after answer");
	req_hold_a: assert property (req && !ack |=>
		req && $stable(addr) && $stable(wdata) && $stable(wr))
		else $error("request changed before its answer");
	wr_wait_a: assert property (s_wr_ans |->
		cnt == ((read_wait_states == fcs_pkg::FWS_MAX) ? 5 : read_wait_states + 3))
		else $error("latch write wait count wrong");
	rd_wait_a: assert property (s_rd_ans |-> cnt == read_wait_states + 2)
		else $error("flash read wait count wrong");
	reg_wait_a: assert property (ack && req && regsp |-> cnt == 2)
		else $error("register answer not after one cycle");
	done_clr_a: assert property (s_cmd_done_ie |-> ##1 !irq)
		else $error("interrupt kept after command write");
	rej_irq_a: assert property (s_bad_key |-> ##[3:5] irq)
		else $error("no interrupt after refused command");
	irq_off_a: assert property ((ie == 3'h0)[*3] |-> !irq)
		else $error("interrupt with all enables off");
	word_size_a: assert property (req |-> size == fcs_pkg::SZ_WORD)
		else $error("link transfer not a whole word");
endmodule : fcs_asserts

/* bench/fcs_tb.sv */
// testbench: host and sequencer back to back, driven over AHB-Lite
// assumes the fcs_pkg map, a 10 MHz clock and us_cycle_count 0, but 200 for the first lock in t_lock
`timescale 1ns/1ps
module fcs_tb;
	logic clk_sys_i;
	logic reset_n_i;
	logic [31:0] haddr, hwdata, hrdata, r, wdat;
	logic [31:0] mem [64];
	logic [1:0] htrans;
	logic [2:0] hsize, gp;
	logic hwrite, hready, ext_erase, aw, ae, awp, sec;
	logic [15:0] aa;
	logic [19:0] ra;
	logic [9:0] wpage, epage;
	int error_cnt, n_tests, wcnt, ecnt, xcnt;
	fcs_if i_fcs_if();
	fcs_host i_fcs_host(.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
		.hreadyout_o(hready), .hresp_o(), .hrdata_o(hrdata), .bus(i_fcs_if));
	fcs_device i_fcs_device(.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.bus(i_fcs_if), .arr_erase_o(ae), .arr_wipe_o(awp), .arr_wr_o(aw),
		.arr_addr_o(aa), .arr_wdata_o(wdat), .arr_rd_addr_o(ra),
		.arr_rd_data_i({12'hC3A, ra}), .ext_erase_i(ext_erase),
		.security_o(sec), .gp_nvm_o(gp));
	fcs_asserts i_fcs_asserts(.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.req(i_fcs_if.req), .wr(i_fcs_if.wr), .size(i_fcs_if.size),
		.addr(i_fcs_if.addr), .wdata(i_fcs_if.wdata), .ack(i_fcs_if.ack),
		.irq(i_fcs_if.irq));
	// free-running system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// array activity log, judged after the program and erase commands
	always @(posedge clk_sys_i) begin
		if (aw) begin
			mem[aa[5:0]] = wdat;
			wpage = aa[15:6];
			wcnt++;
		end
		if (ae) begin
			ecnt++;
			epage = aa[15:6];
		end
		if (awp)
			xcnt++;
	end
	task stop_test;
		$display("errors=%0d compares=%0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one single word transfer; no wait count assumed, the watchdog bounds it
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		r = hrdata;
	endtask : ahb
	// one link transfer through the host registers, answer left in r
	task lnk(input logic w, input logic [20:0] a, input logic [31:0] d);
		ahb(1'b1, fcs_pkg::H_ADDR, {11'h0, a});
		ahb(1'b1, fcs_pkg::H_WDATA, d);
		ahb(1'b1, fcs_pkg::H_GO, {29'h0, fcs_pkg::SZ_WORD, w});
		do ahb(1'b0, fcs_pkg::H_STAT, 32'h0); while (r[0] !== 1'b0);
		ahb(1'b0, fcs_pkg::H_RDATA, 32'h0);
	endtask : lnk
	task rg(input logic w, input logic [7:0] off, input logic [31:0] d);
		lnk(w, {1'b1, 12'h0, off}, d);
	endtask : rg
	task cmd(input logic bad, input logic [9:0] idx, input logic [3:0] c);
		rg(1'b1, fcs_pkg::CMD_OFF, {bad ? ~fcs_pkg::CMD_KEY :
			fcs_pkg::CMD_KEY, 6'h0, idx, 4'h0, c});
	endtask : cmd
	// the status read that sees done also carries the flags
	task wdone;
		do rg(1'b0, fcs_pkg::STAT_OFF, 32'h0); while (r[0] !== 1'b1);
	endtask : wdone
	task run(input logic bad, input logic [9:0] idx, input logic [3:0] c,
		input logic [31:0] exp);
		cmd(bad, idx, c);
		wdone;
		chk(r, exp);
	endtask : run
	task t_ref;
		rg(1'b0, fcs_pkg::CFG_OFF, 32'h0);
		chk(r, fcs_pkg::CFG_RESET);
		rg(1'b0, fcs_pkg::STAT_OFF, 32'h0);
		chk(r, 32'h0000_0001);
		rg(1'b1, fcs_pkg::CFG_OFF, 32'h0000_0109);
		rg(1'b0, fcs_pkg::CFG_OFF, 32'h0);
		chk(r, 32'h0000_0109);
		run(1'b1, 10'h045, fcs_pkg::C_LOCK, 32'h0000_0009);
		rg(1'b0, fcs_pkg::STAT_OFF, 32'h0);
		chk(r, 32'h0000_0001);
		run(1'b0, 10'h045, 4'h5, 32'h0000_0009);
	endtask : t_ref
	task t_lock;
		rg(1'b1, fcs_pkg::CFG_OFF, 32'h00C8_0101);
		cmd(1'b0, 10'h045, fcs_pkg::C_LOCK);
		lnk(1'b0, 21'h00124, 32'h0);
		chk(r, 32'hC3A0_0124);
		wdone;
		chk(r, 32'h0002_0001);
		// lock fault interrupt alone; done interrupt off so irq means lockf
		rg(1'b1, fcs_pkg::CFG_OFF, 32'h0000_0104);
		run(1'b0, 10'h050, fcs_pkg::C_PROG, 32'h0002_0005);
		chk(32'(wcnt + ecnt), 32'h0);
		cmd(1'b0, 10'h3FF, fcs_pkg::C_WIPE);
		// irq seen on the host status before the status read clears lockf
		ahb(1'b0, fcs_pkg::H_STAT, 32'h0);
		chk(r, 32'h0000_0002);
		wdone;
		chk(r, 32'h0002_0005);
		chk(32'(xcnt), 32'h0);
		run(1'b0, 10'h07F, fcs_pkg::C_UNLOCK, 32'h0000_0001);
		run(1'b0, 10'h000, fcs_pkg::C_WIPE, 32'h0000_0001);
		chk(32'(xcnt), 32'h1);
	endtask : t_lock
	task t_gp;
		rg(1'b1, fcs_pkg::CFG_OFF, 32'h0);
		for (int i = 0; i < 4; i++) begin
			run(1'b0, 10'(i), fcs_pkg::C_GP_SET,
				(i < 3) ? 32'h1 | (32'h100 << i) : 32'h1);
			chk({29'h0, gp}, (i < 3) ? 32'h1 << i : 32'h0);
			run(1'b0, 10'(i), fcs_pkg::C_GP_CLR, 32'h1);
		end
	endtask : t_gp
	// latch filled through aliased addresses, then program and lock
	task t_prog;
		rg(1'b1, fcs_pkg::CFG_OFF, 32'h0000_0301);
		for (int i = 0; i < 64; i++)
			lnk(1'b1, {1'b0, 6'(i), 6'h2B, 6'(i), 2'b00}, 32'hD00D_0000 + i);
		run(1'b0, 10'h0C3, fcs_pkg::C_PROG_LOCK, 32'h0008_0001);
		chk(32'(ecnt), 32'h1);
		chk(32'(wcnt), 32'h40);
		chk({22'h0, epage}, 32'h0000_00C3);
		chk({22'h0, wpage}, 32'h0000_00C3);
		for (int i = 0; i < 64; i++)
			chk(mem[i], 32'hD00D_0000 + i);
		rg(1'b1, fcs_pkg::CFG_OFF, 32'h0000_0381);
		run(1'b0, 10'h0C3, fcs_pkg::C_UNLOCK, 32'h0000_0001);
		run(1'b0, 10'h0C3, fcs_pkg::C_PROG, 32'h0000_0001);
		chk(32'(ecnt), 32'h1);
		chk(32'(wcnt), 32'h80);
	endtask : t_prog
	task t_sec;
		run(1'b0, 10'h080, fcs_pkg::C_LOCK, 32'h0004_0001);
		run(1'b0, 10'h001, fcs_pkg::C_GP_SET, 32'h0004_0201);
		run(1'b0, 10'h000, fcs_pkg::C_SEC, 32'h0004_0211);
		chk({31'h0, sec}, 32'h1);
		ext_erase <= 1'b1;
		repeat (150) @(posedge clk_sys_i);
		ext_erase <= 1'b0;
		rg(1'b0, fcs_pkg::STAT_OFF, 32'h0);
		chk(r, 32'h0000_0001);
		chk({28'h0, sec, gp}, 32'h0);
		chk(32'(xcnt), 32'h2);
	endtask : t_sec
	// reset, then the scenarios in order
	initial begin
		reset_n_i = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		ext_erase = 1'b0;
		repeat (16) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		@(posedge clk_sys_i);
		t_ref;
		t_lock;
		t_gp;
		t_prog;
		t_sec;
		stop_test;
	end
	// watchdog: the whole run needs well under a tenth of this
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		error_cnt++;
		stop_test;
	end
endmodule : fcs_tb
